// ===== fp_class_pkg.sv
// What this block does
// - Q15 is 16-bit signed, sign bit 15
// - Qm.n storage width is m+n+1, sign top
// - Single word: sign, 8-bit exponent, 23-bit fraction
// - Double word: sign, 11-bit exponent, 52-bit fraction
// - Sign zero positive, sign one negative
// - Double in even/odd pair, high in odd
// - Low half written one cycle before high
// - Dependent low-first reader may issue with high write
// - Single normal 0<e<255; e=0, f nonzero subnormal
// - Double normal 0<e<2047; e=0, f nonzero subnormal
// - Single zero, infinity, quiet/signalling NaN by fraction top
// - Double uses same classes with exponent 2047
// - Default NaN: sign clear, all fraction ones
// - Single reference encodings one, extremes, smallest subnormal
// - Double reference encodings one, extremes, smallest subnormal
package fp_class_pkg;

  localparam int Q15_W = 16;
  localparam int Q15_SIGN = 15;
  localparam int SP_W = 32;
  localparam int SP_EXP_W = 8;
  localparam int SP_FRAC_W = 23;
  localparam int DP_W = 64;
  localparam int DP_EXP_W = 11;
  localparam int DP_FRAC_W = 52;
  localparam int HALF_W = 32;
  localparam int REG_IDX_W = 5;

  // Field slots are sized for double; single fields sit in the low bits
  localparam int EXP_W = DP_EXP_W;
  localparam int FRAC_W = DP_FRAC_W;

  localparam logic [SP_W-1:0] SP_DEFAULT_QUIET_PATTERN = 32'h7fffffff;
  localparam logic [SP_W-1:0] SP_ONE = 32'h3f800000;
  localparam logic [SP_W-1:0] SP_LARGEST_NORMAL = 32'h7f7fffff;
  localparam logic [SP_W-1:0] SP_SMALLEST_NORMAL = 32'h00800000;
  localparam logic [SP_W-1:0] SP_LARGEST_SUBNORMAL = 32'h007fffff;
  localparam logic [SP_W-1:0] SP_SMALLEST_SUBNORMAL = 32'h00000001;
  localparam logic [DP_W-1:0] DP_DEFAULT_QUIET_PATTERN =
    64'h7fffffffffffffff;
  localparam logic [DP_W-1:0] DP_ONE = 64'h3ff0000000000000;
  localparam logic [DP_W-1:0] DP_LARGEST_NORMAL = 64'h7fefffffffffffff;
  localparam logic [DP_W-1:0] DP_SMALLEST_NORMAL = 64'h0010000000000000;
  localparam logic [DP_W-1:0] DP_LARGEST_SUBNORMAL = 64'h000fffffffffffff;
  localparam logic [DP_W-1:0] DP_SMALLEST_SUBNORMAL = 64'h0000000000000001;

  typedef enum logic [1:0] {
    FMT_Q15,
    FMT_SINGLE,
    FMT_DOUBLE,
    FMT_QMN
  } fmt_t;

  typedef enum logic [2:0] {
    REF_DEFAULT_QUIET_PATTERN,
    REF_ONE,
    REF_LARGEST_NORMAL,
    REF_SMALLEST_NORMAL,
    REF_LARGEST_SUBNORMAL,
    REF_SMALLEST_SUBNORMAL
  } ref_sel_t;

  // One-hot class, bit order fixed for the whole block
  typedef struct packed {
    logic signalling_nan;
    logic quiet_nan;
    logic infinity;
    logic normal;
    logic subnormal;
    logic zero;
  } class_t;

  typedef struct packed {
    logic sign;
    logic [EXP_W-1:0] exponent;
    logic [FRAC_W-1:0] fraction;
  } fields_t;

  typedef struct packed {
    logic valid;
    logic [REG_IDX_W-1:0] idx;
    logic [HALF_W-1:0] data;
  } rf_write_t;

endpackage

// ===== fp_field_classify.sv
`timescale 1ns/1ps
// Combinational classifier for one IEEE width
module fp_field_classify
  import fp_class_pkg::*;
#(
  parameter int EW = 8,
  parameter int FW = 23
) (
  // Operand
  input wire logic [EW+FW:0] word,
  // Result
  output class_t cls,
  output fields_t fields
);

  wire logic sign = word[EW+FW];
  wire logic [EW-1:0] exp_f = word[EW+FW-1:FW];
  wire logic [FW-1:0] frac_f = word[FW-1:0];
  wire logic exp_zero = (exp_f == '0);
  wire logic exp_ones = (exp_f == '1);
  wire logic frac_zero = (frac_f == '0);
  wire logic frac_top = frac_f[FW-1];

  assign cls.zero = exp_zero && frac_zero;
  assign cls.subnormal = exp_zero && !frac_zero;
  assign cls.normal = !exp_zero && !exp_ones;
  assign cls.infinity = exp_ones && frac_zero;
  assign cls.quiet_nan = exp_ones && frac_top;
  assign cls.signalling_nan = exp_ones && !frac_top && !frac_zero;

  assign fields.sign = sign;
  assign fields.exponent = EXP_W'(exp_f);
  assign fields.fraction = FRAC_W'(frac_f);

endmodule

// ===== dp_pair_writer.sv
`timescale 1ns/1ps
// Splits a double result into two register-file writes, low half first
module dp_pair_writer
  import fp_class_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Producer
  input wire logic res_valid,
  input wire logic [REG_IDX_W-1:0] res_pair,
  input wire logic [DP_W-1:0] res_data,
  // Register file write port
  output rf_write_t rf_wr,
  output logic high_phase
);

  logic pend_q;
  logic pend_d;
  logic [REG_IDX_W-1:0] idx_q;
  logic [REG_IDX_W-1:0] idx_d;
  logic [HALF_W-1:0] hi_q;
  logic [HALF_W-1:0] hi_d;
  rf_write_t wr_q;
  rf_write_t wr_d;

  // Even register is the pair base with bit 0 forced clear
  wire logic [REG_IDX_W-1:0] even_idx = {res_pair[REG_IDX_W-1:1], 1'b0};
  wire logic [REG_IDX_W-1:0] odd_idx = {idx_q[REG_IDX_W-1:1], 1'b1};
  // A result arriving in the cycle after a take is dropped, not queued;
  // the producer must space results two cycles apart
  wire logic take = res_valid && !pend_q;

  assign pend_d = take;
  assign idx_d = take ? even_idx : idx_q;
  assign hi_d = take ? res_data[DP_W-1:HALF_W] : hi_q;
  assign wr_d.valid = take || pend_q;
  assign wr_d.idx = pend_q ? odd_idx : even_idx;
  assign wr_d.data = pend_q ? hi_q : res_data[HALF_W-1:0];

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      pend_q <= 1'b0;
      idx_q <= '0;
      hi_q <= '0;
      wr_q <= '0;
    end else begin
      pend_q <= pend_d;
      idx_q <= idx_d;
      hi_q <= hi_d;
      wr_q <= wr_d;
    end
  end

  assign rf_wr = wr_q;
  // A low-first reader of this pair may issue while this is high
  assign high_phase = wr_q.valid && wr_q.idx[0];

endmodule

// ===== fp_format_classifier.sv
`timescale 1ns/1ps
module fp_format_classifier
  import fp_class_pkg::*;
#(
  parameter int QM_INT = 0,
  parameter int QM_FRAC = 15
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Operand capture
  input wire logic op_valid,
  input wire fmt_t op_fmt,
  input wire logic [DP_W-1:0] op_word,
  // Classification result
  output logic res_valid,
  output class_t res_class,
  output fields_t res_fields,
  output logic res_negative,
  output logic [Q15_W-2:0] q15_fraction,
  // Reference encodings
  input wire ref_sel_t ref_sel,
  output logic [SP_W-1:0] ref_single,
  output logic [DP_W-1:0] ref_double,
  // Double result write to register file
  input wire logic dp_res_valid,
  input wire logic [REG_IDX_W-1:0] dp_res_pair,
  input wire logic [DP_W-1:0] dp_res_data,
  output rf_write_t rf_wr,
  output logic rf_high_phase
);

  //////////////////////////////////////////////////////////////////////
  // Field split for each format

  localparam int QM_W = QM_INT + QM_FRAC + 1;

  class_t sp_cls;
  class_t dp_cls;
  fields_t sp_fields;
  fields_t dp_fields;

  fp_field_classify #(.EW(SP_EXP_W), .FW(SP_FRAC_W)) u_sp (
    .word(op_word[SP_W-1:0]),
    .cls(sp_cls),
    .fields(sp_fields)
  );

  fp_field_classify #(.EW(DP_EXP_W), .FW(DP_FRAC_W)) u_dp (
    .word(op_word),
    .cls(dp_cls),
    .fields(dp_fields)
  );

  // Fixed-point words have no exponent; class reports zero or normal
  wire logic q15_sign = op_word[Q15_SIGN];
  wire logic [Q15_W-2:0] q15_frac = op_word[Q15_SIGN-1:0];
  wire logic qm_sign = op_word[QM_W-1];
  wire logic [QM_W-2:0] qm_mag = op_word[QM_W-2:0];

  wire logic q15_zero = (op_word[Q15_W-1:0] == '0);
  wire logic qm_zero = (op_word[QM_W-1:0] == '0);

  class_t fx_cls;
  fields_t fx_fields;
  wire logic fx_zero = (op_fmt == FMT_Q15) ? q15_zero : qm_zero;
  wire logic fx_sign = (op_fmt == FMT_Q15) ? q15_sign : qm_sign;

  assign fx_cls = '{signalling_nan: 1'b0, quiet_nan: 1'b0,
                    infinity: 1'b0, normal: !fx_zero, subnormal: 1'b0,
                    zero: fx_zero};
  assign fx_fields.sign = fx_sign;
  assign fx_fields.exponent = '0;
  assign fx_fields.fraction = (op_fmt == FMT_Q15) ?
    FRAC_W'(q15_frac) : FRAC_W'(qm_mag);

  //////////////////////////////////////////////////////////////////////
  // Format select and result register

  class_t cls_d;
  fields_t fields_d;

  assign cls_d = (op_fmt == FMT_SINGLE) ? sp_cls :
                 (op_fmt == FMT_DOUBLE) ? dp_cls : fx_cls;
  assign fields_d = (op_fmt == FMT_SINGLE) ? sp_fields :
                    (op_fmt == FMT_DOUBLE) ? dp_fields : fx_fields;

  logic valid_q;
  class_t cls_q;
  fields_t fields_q;
  logic [Q15_W-2:0] q15_q;

  // Result holds its last value between captures
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      valid_q <= 1'b0;
      cls_q <= '0;
      fields_q <= '0;
      q15_q <= '0;
    end else begin
      valid_q <= op_valid;
      if (op_valid) begin
        cls_q <= cls_d;
        fields_q <= fields_d;
        q15_q <= q15_frac;
      end
    end
  end

  assign res_valid = valid_q;
  assign res_class = cls_q;
  assign res_fields = fields_q;
  assign res_negative = fields_q.sign;
  assign q15_fraction = q15_q;

  //////////////////////////////////////////////////////////////////////
  // Reference encodings, registered

  logic [SP_W-1:0] ref_sp_d;
  logic [DP_W-1:0] ref_dp_d;
  logic [SP_W-1:0] ref_sp_q;
  logic [DP_W-1:0] ref_dp_q;

  always_comb begin
    case (ref_sel)
      REF_DEFAULT_QUIET_PATTERN: begin
        ref_sp_d = SP_DEFAULT_QUIET_PATTERN;
        ref_dp_d = DP_DEFAULT_QUIET_PATTERN;
      end
      REF_ONE: begin
        ref_sp_d = SP_ONE;
        ref_dp_d = DP_ONE;
      end
      REF_LARGEST_NORMAL: begin
        ref_sp_d = SP_LARGEST_NORMAL;
        ref_dp_d = DP_LARGEST_NORMAL;
      end
      REF_SMALLEST_NORMAL: begin
        ref_sp_d = SP_SMALLEST_NORMAL;
        ref_dp_d = DP_SMALLEST_NORMAL;
      end
      REF_LARGEST_SUBNORMAL: begin
        ref_sp_d = SP_LARGEST_SUBNORMAL;
        ref_dp_d = DP_LARGEST_SUBNORMAL;
      end
      REF_SMALLEST_SUBNORMAL: begin
        ref_sp_d = SP_SMALLEST_SUBNORMAL;
        ref_dp_d = DP_SMALLEST_SUBNORMAL;
      end
      default: begin
        ref_sp_d = SP_DEFAULT_QUIET_PATTERN;
        ref_dp_d = DP_DEFAULT_QUIET_PATTERN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ref_sp_q <= '0;
      ref_dp_q <= '0;
    end else begin
      ref_sp_q <= ref_sp_d;
      ref_dp_q <= ref_dp_d;
    end
  end

  assign ref_single = ref_sp_q;
  assign ref_double = ref_dp_q;

  //////////////////////////////////////////////////////////////////////
  // Double result write ordering

  dp_pair_writer u_wr (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .res_valid(dp_res_valid),
    .res_pair(dp_res_pair),
    .res_data(dp_res_data),
    .rf_wr(rf_wr),
    .high_phase(rf_high_phase)
  );

endmodule

// ===== fp_format_classifier_monitor.sv
`timescale 1ns/1ps
module fp_format_classifier_monitor
  import fp_class_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Classifier
  input wire logic op_valid,
  input wire fmt_t op_fmt,
  input wire logic [DP_W-1:0] op_word,
  input wire logic res_valid,
  input wire class_t res_class,
  input wire logic res_negative,
  // References
  input wire ref_sel_t ref_sel,
  input wire logic [SP_W-1:0] ref_single,
  input wire logic [DP_W-1:0] ref_double,
  // Pair writer
  input wire logic dp_res_valid,
  input wire logic [DP_W-1:0] dp_res_data,
  input wire rf_write_t rf_wr,
  input wire logic rf_high_phase
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  a_res_latency: assert property (op_valid |=> res_valid)
    else $error("result strobe missing after capture");
  a_res_cause: assert property (res_valid |-> $past(op_valid))
    else $error("result strobe without capture");
  a_class_onehot: assert property (res_valid |-> $onehot(res_class))
    else $error("class vector not one-hot");
  a_sp_quiet: assert property (op_valid && op_fmt == FMT_SINGLE &&
    &op_word[30:23] && op_word[22] |=> res_class.quiet_nan)
    else $error("single quiet class missing");
  a_sp_signal: assert property (op_valid && op_fmt == FMT_SINGLE &&
    &op_word[30:23] && !op_word[22] && |op_word[21:0]
    |=> res_class.signalling_nan)
    else $error("single signalling class missing");
  a_dp_signal: assert property (op_valid && op_fmt == FMT_DOUBLE &&
    &op_word[62:52] && !op_word[51] && |op_word[50:0]
    |=> res_class.signalling_nan)
    else $error("double signalling class missing");
  a_dp_sign: assert property (op_valid && op_fmt == FMT_DOUBLE
    |=> res_negative == $past(op_word[63]))
    else $error("double sign wrong");
  // A second strobe right after a take is dropped, so only fresh ones count
  a_low_first: assert property (dp_res_valid && !$past(dp_res_valid)
    |=> rf_wr.valid && !rf_wr.idx[0] && !rf_high_phase &&
    rf_wr.data == $past(dp_res_data[31:0])
    ##1 rf_wr.valid && rf_wr.idx[0] && rf_high_phase)
    else $error("pair write order wrong");
  a_high_data: assert property (rf_high_phase |-> rf_wr.valid &&
    rf_wr.data == $past(dp_res_data[63:32], 2))
    else $error("high half data wrong");
  a_ref_one: assert property (ref_sel == REF_ONE |=>
    ref_single == SP_ONE && ref_double == DP_ONE)
    else $error("unit encoding wrong");
  a_ref_nan: assert property (ref_sel == REF_DEFAULT_QUIET_PATTERN |=>
    ref_single == SP_DEFAULT_QUIET_PATTERN &&
    ref_double == DP_DEFAULT_QUIET_PATTERN)
    else $error("default quiet pattern wrong");
endmodule

bind fp_format_classifier fp_format_classifier_monitor
  i_fp_format_classifier_monitor (.*);

// ===== rf_pair_model.sv
`timescale 1ns/1ps
module rf_pair_model
  import fp_class_pkg::*;
(
  // Write port from the block
  input wire logic clk_sys,
  input wire rf_write_t rf_wr,
  // Pair read, either index of the pair
  input wire logic [REG_IDX_W-1:0] rd_pair,
  output logic [DP_W-1:0] rd_data
);
  logic [HALF_W-1:0] regs [32];
  always @(posedge clk_sys) begin
    if (rf_wr.valid) regs[rf_wr.idx] <= rf_wr.data;
  end
  // Read is combinational so a low-first reader sees the low half early
  assign rd_data = {regs[{rd_pair[4:1], 1'b1}],
    regs[{rd_pair[4:1], 1'b0}]};
endmodule

// ===== fp_format_classifier_test.sv
`timescale 1ns/1ps
module fp_format_classifier_test;
  import fp_class_pkg::*;
  localparam logic [63:0] W [16] = '{64'h0, 64'h80000000, 64'h1,
    64'h7fffff, 64'h800000, 64'h7f7fffff, 64'hff800000, 64'h7fc00000,
    64'h0, 64'h8000000000000001, 64'h0010000000000000,
    64'h7fefffffffffffff, 64'hfff0000000000000, 64'h7ff8000000000000,
    64'h7ff0000000000001, 64'h000fffffffffffff};
  localparam int K [16] = '{0, 0, 1, 1, 2, 2, 3, 4, 0, 1, 2, 2, 3, 4, 5, 1};
  localparam logic [31:0] SR [7] = '{32'h7fffffff, 32'h3f800000,
    32'h7f7fffff, 32'h800000, 32'h7fffff, 32'h1, 32'h7fffffff};
  localparam logic [63:0] DR [7] = '{64'h7fffffffffffffff,
    64'h3ff0000000000000, 64'h7fefffffffffffff, 64'h0010000000000000,
    64'h000fffffffffffff, 64'h1, 64'h7fffffffffffffff};
  logic clk_sys, reset_n, op_valid, dp_res_valid;
  fmt_t op_fmt;
  ref_sel_t ref_sel;
  logic [63:0] op_word, dp_res_data, ref_double, rd_data, w;
  logic [4:0] dp_res_pair;
  logic res_valid, res_negative, rf_high_phase;
  class_t res_class;
  fields_t res_fields;
  logic [14:0] q15_fraction;
  logic [31:0] ref_single;
  rf_write_t rf_wr;
  int n_errors, n_checks;

  fp_format_classifier i_fp_format_classifier (.*);
  rf_pair_model i_rf_pair_model (.clk_sys(clk_sys), .rf_wr(rf_wr),
    .rd_pair(dp_res_pair), .rd_data(rd_data));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task chk(input string nm, input logic [63:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Fixed one-cycle answer, so the result is read just after the take
  task op(input fmt_t f, input logic [63:0] v);
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_fmt <= f;
    op_word <= v;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    #1;
    chk("res_valid", 64'h1, res_valid);
  endtask

  task t_ieee;
    for (int i = 0; i < 16; i++) begin
      w = W[i];
      op(i < 8 ? FMT_SINGLE : FMT_DOUBLE, w);
      chk("class", 64'h1 << K[i], res_class);
      if (i < 8) begin
        chk("sp_sign", w[31], res_negative);
        chk("sp_exp", w[30:23], res_fields.exponent);
        chk("sp_frac", w[22:0], res_fields.fraction);
      end else begin
        chk("dp_sign", w[63], res_negative);
        chk("dp_exp", w[62:52], res_fields.exponent);
        chk("dp_frac", w[51:0], res_fields.fraction);
      end
    end
    // Single signalling pattern: top fraction bit clear, rest nonzero
    op(FMT_SINGLE, 64'h7f800001);
    chk("sp_signalling_nan", 64'h20, res_class);
    $display("ieee classes done");
  endtask

  task t_fixed;
    op(FMT_Q15, 64'h8001);
    chk("q15_class", 64'h4, res_class);
    chk("q15_sign", 64'h1, res_negative);
    chk("q15_frac", 64'h1, q15_fraction);
    op(FMT_QMN, 64'h0);
    chk("qmn_zero", 64'h1, res_class);
    op(FMT_QMN, 64'h7fff);
    chk("qmn_sign", 64'h0, res_negative);
    $display("fixed formats done");
  endtask

  task t_refs;
    for (int s = 0; s < 7; s++) begin
      @(posedge clk_sys);
      ref_sel <= ref_sel_t'(s);
      @(posedge clk_sys);
      #1;
      chk("ref_single", SR[s], ref_single);
      chk("ref_double", DR[s], ref_double);
    end
    $display("references done");
  endtask

  task t_pair;
    @(posedge clk_sys);
    dp_res_valid <= 1'b1;
    dp_res_pair <= 5'd7;
    dp_res_data <= 64'hc0000001_12345678;
    // Second strobe inside the pending window must be dropped
    @(posedge clk_sys);
    dp_res_data <= 64'h0;
    #1;
    chk("rf_low", {1'b1, 5'd6, 32'h12345678}, rf_wr);
    @(posedge clk_sys);
    dp_res_valid <= 1'b0;
    #1;
    chk("rf_high", {1'b1, 5'd7, 32'hc0000001}, rf_wr);
    chk("early_low", 64'h12345678, rd_data[31:0]);
    @(posedge clk_sys);
    #1;
    chk("rf_idle", 64'h0, rf_wr.valid);
    chk("pair", 64'hc0000001_12345678, rd_data);
    $display("pair write done");
  endtask

  initial begin
    reset_n = 1'b0;
    op_valid = 1'b0;
    op_fmt = FMT_Q15;
    op_word = 64'h0;
    // One of the checked codes; t_refs drives each code a cycle before checking it
    ref_sel = REF_SMALLEST_NORMAL;
    dp_res_valid = 1'b0;
    dp_res_pair = 5'h0;
    dp_res_data = 64'h0;
    repeat (12) @(posedge clk_sys);
    #1;
    chk("reset_class", 64'h0, res_class);
    @(posedge clk_sys);
    reset_n <= 1'b1;
    t_ieee;
    t_fixed;
    t_refs;
    t_pair;
    complete_run;
  end

  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
endmodule
